// *** dv/test_video_error_status_flags.sv ***
// Self-checking bench of the error flag bank.
// Assumes vesf_top, vesf_host_model and the bound checker are compiled.
`timescale 1ns/1ps
`include "vesf_map.svh"

module test_video_error_status_flags import vesf_pkg::*;;
    typedef struct packed {
        logic [2:0] md;
        logic       fw;
        logic       edh;
        vesf_word_t dis;
        vesf_word_t exp;
        vesf_code_t lc, cc, xl, xc;
    } vesf_row_t;

    // Mode is {rate pin, asi, data-through}; all ten events fire per row
    vesf_row_t  rows [7] = '{
        '{3'b000, 1'b1, 1'b0, 16'h0000, 16'h047f, 4'h3, 4'h8, 4'h3, 4'h8},
        '{3'b100, 1'b1, 1'b1, 16'h0000, 16'h0723, 4'h6, 4'h2, 4'h6, 4'hf},
        '{3'b100, 1'b0, 1'b0, 16'h0000, 16'h0420, 4'hc, 4'h1, 4'hf, 4'hf},
        '{3'b110, 1'b1, 1'b1, 16'h0000, 16'h0000, 4'h7, 4'h3, 4'h7, 4'hf},
        '{3'b001, 1'b1, 1'b1, 16'h0000, 16'h0000, 4'h6, 4'h6, 4'hf, 4'hf},
        '{3'b000, 1'b1, 1'b0, 16'hf8f0, 16'h040f, 4'h0, 4'h5, 4'h0, 4'h5},
        '{3'b000, 1'b0, 1'b0, 16'h0000, 16'h047c, 4'h8, 4'h1, 4'h8, 4'h1}};
    logic [3:0] held [3] = '{4'h5, 4'h9, 4'he};
    logic       clk_sys = 1'b0;
    logic       srst = 1'b1;
    logic [11:0] host_addr;
    logic       host_wr_en, host_rd_en;
    vesf_word_t host_wdata, host_rdata, d;
    logic       locked_pin = 1'b1, comb_n = 1'b1, bypass_n = 1'b1;
    logic       slave = 1'b0, rate = 1'b0, asi = 1'b0, thru = 1'b0;
    logic       fw = 1'b1, edh = 1'b0, fs = 1'b0, sc = 1'b0;
    logic       code_valid = 1'b0, data_error_n;
    logic [9:0] ev = 10'h000;
    vesf_code_t lc = 4'h0, cc = 4'h0, luma_fc, chroma_fc;
    int         n_errors = 0;
    int         n_checks = 0;

    always #25 clk_sys = ~clk_sys;

    vesf_host_model host (.clk_sys(clk_sys), .host_addr(host_addr),
        .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
        .host_wdata(host_wdata), .host_rdata(host_rdata));

    vesf_top i_vesf_top (.clk_sys(clk_sys), .srst(srst),
        .host_addr(host_addr), .host_wr_en(host_wr_en),
        .host_rd_en(host_rd_en), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .locked_pin(locked_pin),
        .combined_reset_n(comb_n), .processing_bypass_n(bypass_n),
        .slave_mode(slave), .rate_select_level(rate),
        .data_error_n(data_error_n), .asi_mode(asi),
        .data_through_mode(thru), .flywheel_enable(fw),
        .edh_packets_ok(edh), .field_start(fs), .std_change(sc),
        .format_mismatch_evt(ev[9]), .full_field_crc_evt(ev[8]),
        .active_picture_crc_evt(ev[7]), .chroma_checksum_evt(ev[6]),
        .luma_checksum_evt(ev[5]), .chroma_line_crc_evt(ev[4]),
        .luma_line_crc_evt(ev[3]), .line_count_evt(ev[2]),
        .start_timing_ref_evt(ev[1]), .end_timing_ref_evt(ev[0]),
        .code_valid(code_valid), .luma_code_in(lc),
        .chroma_code_in(cc), .luma_format_code(luma_fc),
        .chroma_format_code(chroma_fc));

    // ======================================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic mode(input logic [2:0] m, input logic f, input logic e,
                        input vesf_code_t l, input vesf_code_t c);
        @(negedge clk_sys);
        {rate, asi, thru} = m;
        fw = f;
        edh = e;
        lc = l;
        cc = c;
        code_valid = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic pulse(input logic [9:0] e, input logic f, input logic s);
        @(negedge clk_sys);
        ev = e;
        fs = f;
        sc = s;
        @(negedge clk_sys);
        ev = 10'h000;
        fs = 1'b0;
        sc = 1'b0;
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        repeat (6) @(negedge clk_sys);
        srst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({15'h0000, data_error_n}, 16'h0000);
        host.rd(`VESF_ADDR_FLAGS, 1, d);
        chk(d, 16'h0080);
        host.rd(`VESF_ADDR_DISABLE, 1, d);
        chk(d, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            mode(rows[i].md, rows[i].fw, rows[i].edh, rows[i].lc, rows[i].cc);
            host.wr(`VESF_ADDR_DISABLE, rows[i].dis);
            host.rd(`VESF_ADDR_FLAGS, 2, d);
            pulse(10'h3ff, 1'b0, 1'b0);
            chk({15'h0000, data_error_n}, {15'h0000, rows[i].exp == 0});
            host.rd(`VESF_ADDR_FLAGS, 1, d);
            chk(d, rows[i].exp);
            host.rd(`VESF_ADDR_DISABLE, 1, d);
            chk(d, rows[i].dis & 16'h07ff);
            chk({12'h000, luma_fc}, {12'h000, rows[i].xl});
            chk({12'h000, chroma_fc}, {12'h000, rows[i].xc});
            $display("test row %0d done", i);
        end
        mode(3'b000, 1'b1, 1'b0, 4'h3, 4'h8);
        pulse(10'h008, 1'b0, 1'b0);
        pulse(10'h000, 1'b1, 1'b0);
        host.rd(`VESF_ADDR_FLAGS, 1, d);
        chk(d, 16'h0000);
        pulse(10'h008, 1'b0, 1'b0);
        pulse(10'h000, 1'b0, 1'b1);
        host.rd(`VESF_ADDR_FLAGS, 1, d);
        chk(d, 16'h0000);
        pulse(10'h008, 1'b1, 1'b0);
        host.rd(`VESF_ADDR_FLAGS, 1, d);
        chk(d, 16'h0008);
        fork
            host.rd(`VESF_ADDR_FLAGS, 1, d);
            pulse(10'h008, 1'b0, 1'b0);
        join
        chk(d, 16'h0000);
        host.rd(`VESF_ADDR_FLAGS, 1, d);
        chk(d, 16'h0008);
        $display("test clear order done");
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            {comb_n, locked_pin, slave, bypass_n} = held[i];
            repeat (4) @(negedge clk_sys);
            pulse(10'h3ff, 1'b0, 1'b0);
            host.rd(`VESF_ADDR_FLAGS, 1, d);
            chk(d, (i == 1) ? 16'h0080 : 16'h0000);
            @(negedge clk_sys);
            {comb_n, locked_pin, slave, bypass_n} = 4'hd;
            repeat (4) @(negedge clk_sys);
            host.rd(`VESF_ADDR_FLAGS, 1, d);
        end
        $display("test held clears done");
        host.wr(`VESF_ADDR_DISABLE, 16'h0123);
        host.wr(12'h01b, 16'hffff);
        host.rd(12'h01b, 1, d);
        chk(d, 16'h0000);
        host.rd(`VESF_ADDR_DISABLE, 1, d);
        chk(d, 16'h0123);
        $display("test unmapped done");
        @(negedge clk_sys);
        srst = 1'b1;
        repeat (6) @(negedge clk_sys);
        srst = 1'b0;
        chk({12'h000, luma_fc}, 16'h000f);
        chk({12'h000, chroma_fc}, 16'h000f);
        host.rd(`VESF_ADDR_DISABLE, 1, d);
        chk(d, 16'h0000);
        $display("test second reset done");
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
endmodule

// *** dv/vesf_host_model.sv ***
// Host processor model on the register port of the error flag bank.
// Assumes it shares clk_sys; requests change at falling edges.
`timescale 1ns/1ps
`include "vesf_map.svh"

module vesf_host_model
    import vesf_pkg::*;
(
    input  wire logic                    clk_sys,
    output logic [`VESF_ADDR_W-1:0]      host_addr,
    output logic                         host_wr_en,
    output logic                         host_rd_en,
    output vesf_word_t                   host_wdata,
    input  wire vesf_word_t              host_rdata
);
    initial begin
        host_addr  = 12'h000;
        host_wr_en = 1'b0;
        host_rd_en = 1'b0;
        host_wdata = 16'h0000;
    end

    // ======================================================================
    // Bus cycles; released lines show the inverse of their last value
    task automatic wr(input logic [11:0] a, input vesf_word_t d);
        @(negedge clk_sys);
        host_addr  = a;
        host_wdata = d;
        host_wr_en = 1'b1;
        @(negedge clk_sys);
        host_wr_en = 1'b0;
        host_addr  = ~a;
        host_wdata = ~d;
    endtask

    // Holds the read strobe for n back-to-back reads, returns the last
    task automatic rd(input logic [11:0] a, input int n,
                      output vesf_word_t d);
        @(negedge clk_sys);
        host_addr  = a;
        host_rd_en = 1'b1;
        repeat (n) @(negedge clk_sys);
        host_rd_en = 1'b0;
        host_addr  = ~a;
        d          = host_rdata;
    endtask
endmodule

// *** dv/vesf_top_chk.sv ***
// Concurrent checks on the ports of the error flag bank.
// Assumes a single clk_sys domain and synchronous active-high srst.
`timescale 1ns/1ps
`include "vesf_map.svh"

module vesf_top_chk
    import vesf_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    input  wire logic [`VESF_ADDR_W-1:0] host_addr,
    input  wire logic                    host_wr_en,
    input  wire logic                    host_rd_en,
    input  wire vesf_word_t              host_wdata,
    input  wire vesf_word_t              host_rdata,
    input  wire logic                    locked_pin,
    input  wire logic                    rate_select_level,
    input  wire logic                    data_error_n,
    input  wire logic                    asi_mode,
    input  wire logic                    data_through_mode,
    input  wire vesf_code_t              luma_format_code,
    input  wire vesf_code_t              chroma_format_code
);
    // ======================================================================
    // Helper logic
    logic       rd_flags;
    logic       rd_dis;
    logic       wr_dis;
    logic       rd_other;
    vesf_word_t dis_shadow_ff;

    assign rd_flags = host_rd_en && host_addr == `VESF_ADDR_FLAGS;
    assign rd_dis   = host_rd_en && host_addr == `VESF_ADDR_DISABLE;
    assign wr_dis   = host_wr_en && host_addr == `VESF_ADDR_DISABLE;
    assign rd_other = host_rd_en && !rd_flags && !rd_dis;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dis_shadow_ff <= 16'h0000;
        end else if (wr_dis) begin
            dis_shadow_ff <= host_wdata & 16'h07ff;
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    fmt_reset_a: assert property (
        $fell(srst) |-> luma_format_code == 4'hf && chroma_format_code == 4'hf)
        else $error("format codes not unknown after reset");
    fmt_thru_a: assert property (
        data_through_mode |=> luma_format_code == 4'hf
            && chroma_format_code == 4'hf)
        else $error("format codes not unknown in data-through");
    fmt_unlock_a: assert property (
        !locked_pin [*4] |=> luma_format_code == 4'hf
            && chroma_format_code == 4'hf)
        else $error("format codes not unknown without lock");
    chroma_sd_a: assert property (
        (asi_mode || rate_select_level) [*4] |=> chroma_format_code == 4'hf)
        else $error("chroma code not unknown in SD or ASI");
    dis_read_a: assert property (
        rd_dis && !host_wr_en |=> host_rdata == dis_shadow_ff)
        else $error("disable register read back wrong");
    rd_clear_a: assert property (
        rd_flags && data_through_mode ##1 rd_flags
            |=> (host_rdata & 16'hff7f) == 16'h0000)
        else $error("flags not cleared by read");
    pin_or_a: assert property (
        rd_flags |=> ((host_rdata & 16'h07ff) != 16'h0000)
            == !$past(data_error_n))
        else $error("error pin disagrees with stored flags");
    unused_zero_a: assert property (
        host_rdata[15:11] == 5'h00)
        else $error("unused read bits not zero");
    unmapped_a: assert property (
        rd_other |=> host_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind vesf_top vesf_top_chk i_vesf_top_chk (
    .clk_sys(clk_sys), .srst(srst), .host_addr(host_addr),
    .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .locked_pin(locked_pin), .rate_select_level(rate_select_level),
    .data_error_n(data_error_n), .asi_mode(asi_mode),
    .data_through_mode(data_through_mode),
    .luma_format_code(luma_format_code),
    .chroma_format_code(chroma_format_code)
);

// *** verilog/vesf_format.sv ***
// Luma and chroma data format code reporting.
// Assumes code inputs and mode levels come from logic on clk_sys.
`timescale 1ns/1ps
`include "vesf_map.svh"

module vesf_format
    import vesf_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire vesf_mode_t mode,
    input  wire logic       locked,
    input  wire logic       code_valid,
    input  wire vesf_code_t luma_code_in,
    input  wire vesf_code_t chroma_code_in,
    output vesf_code_t      luma_format_code,
    output vesf_code_t      chroma_format_code
);

    // ======================================================================
    // Code filtering
    // Reserved codes are reported as unknown
    function automatic vesf_code_t vesf_clean(input vesf_code_t code);
        vesf_clean = (code > `VESF_CODE_TDM) ? `VESF_CODE_UNKNOWN : code;
    endfunction

    vesf_code_t luma_ff;
    vesf_code_t chroma_ff;
    vesf_code_t nxt_luma;
    vesf_code_t nxt_chroma;
    wire vesf_code_t luma_clean   = vesf_clean(luma_code_in);
    wire vesf_code_t chroma_clean = vesf_clean(chroma_code_in);

    // ======================================================================
    // Next value per mode
    always_comb begin
        nxt_luma   = luma_ff;
        nxt_chroma = chroma_ff;
        if (!locked) begin
            nxt_luma   = `VESF_CODE_UNKNOWN;
            nxt_chroma = `VESF_CODE_UNKNOWN;
        end else begin
            case (mode)
                VESF_MODE_HD: begin
                    if (code_valid) begin
                        nxt_luma   = luma_clean;
                        nxt_chroma = chroma_clean;
                    end
                end
                VESF_MODE_SD, VESF_MODE_ASI: begin
                    if (code_valid) begin
                        nxt_luma = luma_clean;
                    end
                    nxt_chroma = `VESF_CODE_UNKNOWN;
                end
                VESF_MODE_THRU: begin
                    nxt_luma   = `VESF_CODE_UNKNOWN;
                    nxt_chroma = `VESF_CODE_UNKNOWN;
                end
                default: begin
                    nxt_luma   = `VESF_CODE_UNKNOWN;
                    nxt_chroma = `VESF_CODE_UNKNOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            luma_ff   <= `VESF_CODE_UNKNOWN;
            chroma_ff <= `VESF_CODE_UNKNOWN;
        end else begin
            luma_ff   <= nxt_luma;
            chroma_ff <= nxt_chroma;
        end
    end

    assign luma_format_code   = luma_ff;
    assign chroma_format_code = chroma_ff;

endmodule

// *** verilog/vesf_map.svh ***
// Offsets, bit positions, reset values and codes of the error flag bank.
// Assumes inclusion by bare name from any file of the block.
`ifndef VESF_MAP_SVH
`define VESF_MAP_SVH

// ==========================================================================
// Host addresses
`define VESF_ADDR_W           12
`define VESF_ADDR_FLAGS       12'h001
`define VESF_ADDR_DISABLE     12'h01a

// ==========================================================================
// Bit positions shared by flag and disable registers
`define VESF_BIT_STD          10
`define VESF_BIT_FF_CRC       9
`define VESF_BIT_AP_CRC       8
`define VESF_BIT_LOCK         7
`define VESF_BIT_C_CS         6
`define VESF_BIT_Y_CS         5
`define VESF_BIT_C_CRC        4
`define VESF_BIT_Y_CRC        3
`define VESF_BIT_LINE         2
`define VESF_BIT_SAV          1
`define VESF_BIT_EAV          0
`define VESF_NUM_FLAGS        11
`define VESF_USED_BITS        16'h07ff

// ==========================================================================
// Reset values
`define VESF_RST_FLAGS        16'h0000
`define VESF_RST_DISABLE      16'h0000
`define VESF_RST_RDATA        16'h0000
`define VESF_RST_SYNC         5'h00
`define VESF_RST_ERROR_N      1'b1

// ==========================================================================
// Format codes
`define VESF_CODE_SDTI_FIRST  4'h0
`define VESF_CODE_SDTI_LAST   4'h5
`define VESF_CODE_SDI         4'h6
`define VESF_CODE_ASI         4'h7
`define VESF_CODE_TDM         4'h8
`define VESF_CODE_UNKNOWN     4'hf

`endif

// *** verilog/vesf_pkg.sv ***
// Types of the error flag bank.
// Assumes vesf_map.svh for numeric constants.
package vesf_pkg;

    // ======================================================================
    // Types
    typedef logic [15:0] vesf_word_t;
    typedef logic [3:0]  vesf_code_t;

    typedef enum logic [1:0] {
        VESF_MODE_HD,
        VESF_MODE_SD,
        VESF_MODE_ASI,
        VESF_MODE_THRU
    } vesf_mode_t;

endpackage

// *** verilog/vesf_sync.sv ***
// Two-stage synchronisers for the five pin levels of the block.
// Assumes pins are asynchronous to clk_sys and held for several cycles.
`timescale 1ns/1ps
`include "vesf_map.svh"

module vesf_sync
    import vesf_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [4:0] pin_in,
    output logic      [4:0] pin_sync
);

    // ======================================================================
    // Stage registers
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_ff <= `VESF_RST_SYNC;
            sync_ff <= `VESF_RST_SYNC;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;

endmodule

// *** verilog/vesf_top.sv ***
// Error flag collection, detection disable register, error pin and
// data format reporting of the video receiver.
// Assumes detection units give one-cycle event pulses on clk_sys and
// that the host port strobes are one cycle wide and on clk_sys.
`timescale 1ns/1ps
`include "vesf_map.svh"

module vesf_top
    import vesf_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    // Host interface port
    input  wire logic [`VESF_ADDR_W-1:0] host_addr,
    input  wire logic                    host_wr_en,
    input  wire logic                    host_rd_en,
    input  wire vesf_word_t              host_wdata,
    output vesf_word_t                   host_rdata,
    // Pins
    input  wire logic                    locked_pin,
    input  wire logic                    combined_reset_n,
    input  wire logic                    processing_bypass_n,
    input  wire logic                    slave_mode,
    input  wire logic                    rate_select_level,
    output logic                         data_error_n,
    // Mode levels, field start and standard change pulses from device logic
    input  wire logic                    asi_mode,
    input  wire logic                    data_through_mode,
    input  wire logic                    flywheel_enable,
    input  wire logic                    edh_packets_ok,
    input  wire logic                    field_start,
    input  wire logic                    std_change,
    // Detection events
    input  wire logic                    format_mismatch_evt,
    input  wire logic                    full_field_crc_evt,
    input  wire logic                    active_picture_crc_evt,
    input  wire logic                    chroma_checksum_evt,
    input  wire logic                    luma_checksum_evt,
    input  wire logic                    chroma_line_crc_evt,
    input  wire logic                    luma_line_crc_evt,
    input  wire logic                    line_count_evt,
    input  wire logic                    start_timing_ref_evt,
    input  wire logic                    end_timing_ref_evt,
    // Format codes
    input  wire logic                    code_valid,
    input  wire vesf_code_t              luma_code_in,
    input  wire vesf_code_t              chroma_code_in,
    output vesf_code_t                   luma_format_code,
    output vesf_code_t                   chroma_format_code
);

    // ======================================================================
    // Helpers
    function automatic logic vesf_hit(
        input logic [`VESF_ADDR_W-1:0] addr,
        input logic [`VESF_ADDR_W-1:0] target
    );
        vesf_hit = (addr == target);
    endfunction

    // Set wins over a pulse clear, a held clear wins over both for non-lock bits
    function automatic vesf_word_t vesf_update(
        input vesf_word_t cur,
        input vesf_word_t set,
        input vesf_word_t clr
    );
        vesf_update = (cur & ~clr) | set;
    endfunction

    // ======================================================================
    // Pin synchronisation
    logic [4:0] pin_raw;
    logic [4:0] pin_sync;
    logic       locked_s;
    logic       comb_reset_n_s;
    logic       bypass_n_s;
    logic       slave_s;
    logic       rate_sd_s;

    assign pin_raw = {rate_select_level, slave_mode, processing_bypass_n,
                      combined_reset_n, locked_pin};

    vesf_sync u_sync (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .pin_in   (pin_raw),
        .pin_sync (pin_sync)
    );

    assign locked_s       = pin_sync[0];
    assign comb_reset_n_s = pin_sync[1];
    assign bypass_n_s     = pin_sync[2];
    assign slave_s        = pin_sync[3];
    assign rate_sd_s      = pin_sync[4];

    // ======================================================================
    // Operating mode
    vesf_mode_t mode;
    wire logic  hd_mode;
    wire logic  sd_mode;
    wire logic  smpte_active;

    assign mode = data_through_mode ? VESF_MODE_THRU :
                  asi_mode          ? VESF_MODE_ASI  :
                  rate_sd_s         ? VESF_MODE_SD   : VESF_MODE_HD;

    assign hd_mode      = (mode == VESF_MODE_HD);
    assign sd_mode      = (mode == VESF_MODE_SD);
    assign smpte_active = hd_mode | sd_mode;

    // ======================================================================
    // Register storage
    vesf_word_t flags_ff;
    vesf_word_t disable_ff;
    vesf_word_t rdata_ff;
    logic       error_n_ff;
    vesf_word_t nxt_flags;
    vesf_word_t nxt_disable;
    vesf_word_t nxt_rdata;

    // ======================================================================
    // Host decode
    wire logic hit_flags;
    wire logic hit_disable;
    wire logic rd_flags;
    wire logic wr_disable;
    vesf_word_t read_sel;

    assign hit_flags   = vesf_hit(host_addr, `VESF_ADDR_FLAGS);
    assign hit_disable = vesf_hit(host_addr, `VESF_ADDR_DISABLE);
    assign rd_flags    = host_rd_en & hit_flags;
    assign wr_disable  = host_wr_en & hit_disable;

    // ======================================================================
    // Read data
    wire vesf_word_t flags_view;
    wire vesf_word_t disable_view;

    assign flags_view   = flags_ff & `VESF_USED_BITS;
    assign disable_view = disable_ff & `VESF_USED_BITS;

    // Unused bits and unmapped addresses read as zero
    assign read_sel = hit_flags   ? flags_view :
                      hit_disable ? disable_view :
                      `VESF_RST_RDATA;

    assign nxt_rdata   = host_rd_en ? read_sel : rdata_ff;
    assign nxt_disable = wr_disable ?
                         (host_wdata & `VESF_USED_BITS) :
                         disable_ff;

    // ======================================================================
    // Raw error conditions per bit
    vesf_word_t raw_err;
    vesf_word_t set_vec;
    wire logic  gate_smpte;
    wire logic  gate_sd_crc;
    wire logic  gate_hd;
    wire logic  gate_trs;

    assign gate_smpte  = smpte_active;
    assign gate_sd_crc = sd_mode & edh_packets_ok;
    assign gate_hd     = hd_mode;
    assign gate_trs    = smpte_active & flywheel_enable;

    always_comb begin
        raw_err = 16'h0000;
        raw_err[`VESF_BIT_STD] = gate_smpte
            & format_mismatch_evt;
        raw_err[`VESF_BIT_FF_CRC] = gate_sd_crc
            & full_field_crc_evt;
        raw_err[`VESF_BIT_AP_CRC] = gate_sd_crc
            & active_picture_crc_evt;
        raw_err[`VESF_BIT_LOCK] = ~locked_s;
        raw_err[`VESF_BIT_C_CS] = gate_hd
            & chroma_checksum_evt;
        raw_err[`VESF_BIT_Y_CS] = gate_smpte
            & luma_checksum_evt;
        raw_err[`VESF_BIT_C_CRC] = gate_hd
            & chroma_line_crc_evt;
        raw_err[`VESF_BIT_Y_CRC] = gate_hd
            & luma_line_crc_evt;
        raw_err[`VESF_BIT_LINE] = gate_hd
            & line_count_evt;
        raw_err[`VESF_BIT_SAV] = gate_trs
            & start_timing_ref_evt;
        raw_err[`VESF_BIT_EAV] = gate_trs
            & end_timing_ref_evt;
    end

    // ======================================================================
    // Clear conditions
    wire logic      hold_clear;
    wire logic      pulse_clear_all;
    wire vesf_word_t lock_only;
    wire vesf_word_t pulse_clr;
    wire vesf_word_t hold_clr;

    // Level conditions keep non-lock flags at zero for as long as they hold
    assign hold_clear = ~comb_reset_n_s | ~locked_s
                      | (slave_s & ~bypass_n_s);
    assign pulse_clear_all = field_start | rd_flags;
    assign lock_only = 16'h0001 << `VESF_BIT_LOCK;

    assign pulse_clr = pulse_clear_all ? `VESF_USED_BITS :
                       std_change      ? (`VESF_USED_BITS & ~lock_only) :
                       16'h0000;
    assign hold_clr  = hold_clear ? (`VESF_USED_BITS & ~lock_only) :
                       16'h0000;

    // Disabled types never set; held clears override non-lock sets
    assign set_vec = raw_err & ~disable_ff & ~hold_clr;

    // ======================================================================
    // Flag update
    always_comb begin
        nxt_flags = vesf_update(flags_ff & ~hold_clr, set_vec,
                                pulse_clr);
        nxt_flags = nxt_flags & `VESF_USED_BITS;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flags_ff <= `VESF_RST_FLAGS;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // ======================================================================
    // Disable register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            disable_ff <= `VESF_RST_DISABLE;
        end else begin
            disable_ff <= nxt_disable;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= `VESF_RST_RDATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ======================================================================
    // Error pin
    wire logic any_flag;

    assign any_flag = |nxt_flags;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            error_n_ff <= `VESF_RST_ERROR_N;
        end else begin
            error_n_ff <= ~any_flag;
        end
    end

    assign host_rdata   = rdata_ff;
    assign data_error_n = error_n_ff;

    // ======================================================================
    // Data format reporting
    vesf_format u_format (
        .clk_sys            (clk_sys),
        .srst               (srst),
        .mode               (mode),
        .locked             (locked_s),
        .code_valid         (code_valid),
        .luma_code_in       (luma_code_in),
        .chroma_code_in     (chroma_code_in),
        .luma_format_code   (luma_format_code),
        .chroma_format_code (chroma_format_code)
    );

endmodule
